// file: rtl/fan_hysteresis_offset_regs.sv
// Hysteresis, offset and logic-tree test registers with the fan loop floor logic
module fan_hysteresis_offset_regs #(
  parameter int TEMP_W = fan_hyst_pkg::TEMP_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Register port from the serial management engine
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_rd_i,
  output logic [7:0]             reg_rdata_o,
  // Bits held elsewhere in the configuration space
  input  wire logic              global_lock_i,
  input  wire logic              offset_range_i,
  // Raw measurements, two fraction bits
  input  wire logic [TEMP_W-1:0] onchip_temp_i,
  input  wire logic [TEMP_W-1:0] remote_a_temp_i,
  input  wire logic [TEMP_W-1:0] cpu_temp_i,
  input  wire logic [TEMP_W-1:0] remote_b_temp_i,
  // Loop thresholds, whole degrees, and the minimum fan duty
  input  wire logic [7:0]        onchip_start_temp_i,
  input  wire logic [7:0]        remote_a_start_temp_i,
  input  wire logic [7:0]        cpu_start_temp_i,
  input  wire logic [7:0]        remote_b_start_temp_i,
  input  wire logic [7:0]        onchip_crit_limit_i,
  input  wire logic [7:0]        remote_a_crit_limit_i,
  input  wire logic [7:0]        cpu_crit_limit_i,
  input  wire logic [7:0]        remote_b_crit_limit_i,
  input  wire logic [7:0]        min_fan_duty_i,
  // Results
  output logic [TEMP_W-1:0]      onchip_temp_adj_o,
  output logic [TEMP_W-1:0]      remote_a_temp_adj_o,
  output logic [3:0]             fan_running_o,
  output logic [3:0]             fan_crit_o,
  output logic [7:0]             fan_duty_floor_o,
  output logic                   logic_tree_test_on_o
);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  // Whole-degree thresholds need eight integer bits plus the fraction bits
  if (TEMP_W < fan_hyst_pkg::TEMP_W) begin : g_bad_width
    $error("TEMP_W too small for 8-bit thresholds with fraction bits");
  end

  localparam int                CW      = TEMP_W + 2;
  localparam logic [TEMP_W-1:0] SAT_MAX = {1'b0, {(TEMP_W-1){1'b1}}};
  localparam logic [TEMP_W-1:0] SAT_MIN = {1'b1, {(TEMP_W-1){1'b0}}};

  typedef struct packed {
    logic [7:0]        hyst_remote_a_onchip;
    logic [7:0]        hyst_remote_b_cpu;
    logic [7:0]        logic_tree_test_enable;
    logic [7:0]        remote_a_temp_offset;
    logic [7:0]        onchip_temp_offset;
    logic [7:0]        rdata;
    logic [TEMP_W-1:0] onchip_adj;
    logic [TEMP_W-1:0] remote_a_adj;
    logic [7:0]        duty_floor;
  } regs_s;

  regs_s               state_reg;
  regs_s               state_next;
  logic [3:0]          running;
  logic [3:0]          crit;
  logic [TEMP_W-1:0]   ch_temp [fan_hyst_pkg::NUM_CH];
  logic [7:0]          ch_start [fan_hyst_pkg::NUM_CH];
  logic [7:0]          ch_limit [fan_hyst_pkg::NUM_CH];
  logic [3:0]          ch_hyst [fan_hyst_pkg::NUM_CH];

  // ---------------------------------------------------------------------------
  // Offset correction
  // ---------------------------------------------------------------------------
  // Range bit set: one degree steps; clear: half degree steps for finer trim.
  // Result saturates so a large trim never wraps a hot reading to cold.
  function automatic logic [TEMP_W-1:0] add_offset(input logic [TEMP_W-1:0] raw,
                                                    input logic [7:0]        off,
                                                    input logic              wide);
    logic signed [CW-1:0] raw_s;
    logic signed [CW-1:0] off_s;
    logic signed [CW-1:0] sum;
    raw_s = {{2{raw[TEMP_W-1]}}, raw};
    off_s = wide ? {{(CW-10){off[7]}}, off, 2'b00}
                 : {{(CW-9){off[7]}}, off, 1'b0}; // RULE13
    sum   = raw_s + off_s;
    if (sum > $signed({2'b00, SAT_MAX})) begin
      add_offset = SAT_MAX;
    end else if (sum < $signed({2'b11, SAT_MIN})) begin
      add_offset = SAT_MIN;
    end else begin
      add_offset = sum[TEMP_W-1:0];
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Register file and read path
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // Writes are dropped silently while locked; reads still work
    if (reg_wr_i && !global_lock_i) begin // RULE8
      if (reg_addr_i == fan_hyst_pkg::HYST_REMOTE_A_ONCHIP_ADDR) begin
        state_next.hyst_remote_a_onchip = reg_wdata_i;
      end else if (reg_addr_i == fan_hyst_pkg::HYST_REMOTE_B_CPU_ADDR) begin
        state_next.hyst_remote_b_cpu = reg_wdata_i;
      end else if (reg_addr_i == fan_hyst_pkg::LOGIC_TREE_TEST_ADDR) begin
        // Reserved bits are stored as written so software reads back its value
        state_next.logic_tree_test_enable = reg_wdata_i; // RULE10
      end else if (reg_addr_i == fan_hyst_pkg::REMOTE_A_OFFSET_ADDR) begin
        state_next.remote_a_temp_offset = reg_wdata_i;
      end else if (reg_addr_i == fan_hyst_pkg::ONCHIP_OFFSET_ADDR) begin
        state_next.onchip_temp_offset = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == fan_hyst_pkg::HYST_REMOTE_A_ONCHIP_ADDR) begin
        state_next.rdata = state_reg.hyst_remote_a_onchip;
      end else if (reg_addr_i == fan_hyst_pkg::HYST_REMOTE_B_CPU_ADDR) begin
        state_next.rdata = state_reg.hyst_remote_b_cpu;
      end else if (reg_addr_i == fan_hyst_pkg::LOGIC_TREE_TEST_ADDR) begin
        state_next.rdata = state_reg.logic_tree_test_enable;
      end else if (reg_addr_i == fan_hyst_pkg::REMOTE_A_OFFSET_ADDR) begin
        state_next.rdata = state_reg.remote_a_temp_offset;
      end else if (reg_addr_i == fan_hyst_pkg::ONCHIP_OFFSET_ADDR) begin
        state_next.rdata = state_reg.onchip_temp_offset;
      end else begin
        state_next.rdata = fan_hyst_pkg::UNMAPPED_READ;
      end
    end
    state_next.remote_a_adj = add_offset(remote_a_temp_i, state_reg.remote_a_temp_offset,
                                         offset_range_i); // RULE11
    state_next.onchip_adj   = add_offset(onchip_temp_i, state_reg.onchip_temp_offset,
                                         offset_range_i); // RULE12
    // Critical overrides everything; any loop above start keeps the minimum
    if (|crit) begin
      state_next.duty_floor = fan_hyst_pkg::FULL_DUTY; // RULE6
    end else if (|running) begin
      state_next.duty_floor = min_fan_duty_i; // RULE5
    end else begin
      state_next.duty_floor = fan_hyst_pkg::OFF_DUTY;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg.hyst_remote_a_onchip   <= fan_hyst_pkg::HYST_RESET; // RULE14
      state_reg.hyst_remote_b_cpu      <= fan_hyst_pkg::HYST_RESET;
      state_reg.logic_tree_test_enable <= fan_hyst_pkg::TEST_RESET;
      state_reg.remote_a_temp_offset   <= fan_hyst_pkg::OFFSET_RESET;
      state_reg.onchip_temp_offset     <= fan_hyst_pkg::OFFSET_RESET;
      state_reg.rdata                  <= 8'h00;
      state_reg.onchip_adj             <= '0;
      state_reg.remote_a_adj           <= '0;
      state_reg.duty_floor             <= fan_hyst_pkg::OFF_DUTY;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Channel loops
  // ---------------------------------------------------------------------------
  // On-chip and remote A loops see the offset-corrected readings
  assign ch_temp[fan_hyst_pkg::CH_ONCHIP]   = state_reg.onchip_adj;
  assign ch_temp[fan_hyst_pkg::CH_REMOTE_A] = state_reg.remote_a_adj;
  assign ch_temp[fan_hyst_pkg::CH_CPU]      = cpu_temp_i;
  assign ch_temp[fan_hyst_pkg::CH_REMOTE_B] = remote_b_temp_i;

  assign ch_start[fan_hyst_pkg::CH_ONCHIP]   = onchip_start_temp_i;
  assign ch_start[fan_hyst_pkg::CH_REMOTE_A] = remote_a_start_temp_i;
  assign ch_start[fan_hyst_pkg::CH_CPU]      = cpu_start_temp_i;
  assign ch_start[fan_hyst_pkg::CH_REMOTE_B] = remote_b_start_temp_i;

  assign ch_limit[fan_hyst_pkg::CH_ONCHIP]   = onchip_crit_limit_i;
  assign ch_limit[fan_hyst_pkg::CH_REMOTE_A] = remote_a_crit_limit_i;
  assign ch_limit[fan_hyst_pkg::CH_CPU]      = cpu_crit_limit_i;
  assign ch_limit[fan_hyst_pkg::CH_REMOTE_B] = remote_b_crit_limit_i;

  assign ch_hyst[fan_hyst_pkg::CH_ONCHIP] =
    state_reg.hyst_remote_a_onchip[fan_hyst_pkg::LO_NIB_LSB +: fan_hyst_pkg::NIB_W]; // RULE1
  assign ch_hyst[fan_hyst_pkg::CH_REMOTE_A] =
    state_reg.hyst_remote_a_onchip[fan_hyst_pkg::HI_NIB_LSB +: fan_hyst_pkg::NIB_W]; // RULE2
  assign ch_hyst[fan_hyst_pkg::CH_CPU] =
    state_reg.hyst_remote_b_cpu[fan_hyst_pkg::LO_NIB_LSB +: fan_hyst_pkg::NIB_W]; // RULE3
  assign ch_hyst[fan_hyst_pkg::CH_REMOTE_B] =
    state_reg.hyst_remote_b_cpu[fan_hyst_pkg::HI_NIB_LSB +: fan_hyst_pkg::NIB_W]; // RULE4

  for (genvar ch = 0; ch < fan_hyst_pkg::NUM_CH; ch++) begin : g_ch
    hyst_channel #(
      .TEMP_W       (TEMP_W)
    ) u_ch (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .temp_i       (ch_temp[ch]),
      .start_temp_i (ch_start[ch]),
      .crit_limit_i (ch_limit[ch]),
      .hyst_i       (ch_hyst[ch]),
      .running_o    (running[ch]),
      .crit_o       (crit[ch])
    );
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign reg_rdata_o          = state_reg.rdata;
  assign onchip_temp_adj_o    = state_reg.onchip_adj;
  assign remote_a_temp_adj_o  = state_reg.remote_a_adj;
  assign fan_running_o        = running;
  assign fan_crit_o           = crit;
  assign fan_duty_floor_o     = state_reg.duty_floor;
  assign logic_tree_test_on_o =
    state_reg.logic_tree_test_enable[fan_hyst_pkg::TEST_ON_BIT]; // RULE9

endmodule

// file: include/fan_hyst_pkg.sv
// Constants for the fan hysteresis and temperature offset register bank
// Contract
// RULE1: The low nibble of the first hysteresis register sets 0 to 15 degrees for on-chip loops.
// RULE2: The high nibble of the first hysteresis register sets 0 to 15 degrees for remote A.
// RULE3: The low nibble of the second hysteresis register sets 0 to 15 degrees for cpu loops.
// RULE4: The high nibble of the second hysteresis register sets 0 to 15 degrees for remote B.
// RULE5: Below fan-start the fan holds minimum duty until threshold minus hysteresis.
// RULE6: Above the critical limit the fan runs full until below limit minus hysteresis.
// RULE7: Software should not program any hysteresis below 4 degrees to avoid fan cycling.
// RULE8: While the global lock bit is set all these registers ignore writes.
// RULE9: Bit 0 of the test-enable register puts the device into logic-tree pin test mode.
// RULE10: Software must not write the upper seven reserved bits of the test-enable register.
// RULE11: The remote A offset register is added to every remote A measurement.
// RULE12: The on-chip offset register is added to every on-chip measurement.
// RULE13: The offset range bit of the fifth configuration register selects offset range and step.
// RULE14: Hysteresis registers reset to 0x44, test-enable and offset registers reset to zero.
// RULE15: Each hysteresis nibble is an unsigned count of whole degrees taken off the threshold.
package fan_hyst_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] HYST_REMOTE_A_ONCHIP_ADDR = 8'h6d;
  localparam logic [7:0] HYST_REMOTE_B_CPU_ADDR    = 8'h6e;
  localparam logic [7:0] LOGIC_TREE_TEST_ADDR      = 8'h6f;
  localparam logic [7:0] REMOTE_A_OFFSET_ADDR      = 8'h70;
  localparam logic [7:0] ONCHIP_OFFSET_ADDR        = 8'h71;

  // ---------------------------------------------------------------------------
  // Reset values and fields
  // ---------------------------------------------------------------------------
  localparam logic [7:0] HYST_RESET      = 8'h44;
  localparam logic [7:0] TEST_RESET      = 8'h00;
  localparam logic [7:0] OFFSET_RESET    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;
  localparam int         LO_NIB_LSB      = 0;
  localparam int         HI_NIB_LSB      = 4;
  localparam int         NIB_W           = 4;
  localparam int         TEST_ON_BIT     = 0;

  // ---------------------------------------------------------------------------
  // Channels and temperature format
  // ---------------------------------------------------------------------------
  localparam int         NUM_CH          = 4;
  localparam int         CH_ONCHIP       = 0;
  localparam int         CH_REMOTE_A     = 1;
  localparam int         CH_CPU          = 2;
  localparam int         CH_REMOTE_B     = 3;
  localparam int         TEMP_W          = 10;
  localparam int         FRAC_BITS       = 2;
  localparam logic [7:0] FULL_DUTY       = 8'hff;
  localparam logic [7:0] OFF_DUTY        = 8'h00;

endpackage

// file: rtl/hyst_channel.sv
// One temperature channel: fan-start and critical-limit compare with hysteresis
module hyst_channel #(
  parameter int TEMP_W = fan_hyst_pkg::TEMP_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [TEMP_W-1:0] temp_i,
  input  wire logic [7:0]        start_temp_i,
  input  wire logic [7:0]        crit_limit_i,
  input  wire logic [3:0]        hyst_i,
  output logic                   running_o,
  output logic                   crit_o
);

  localparam int CW = TEMP_W + 2;

  // Whole-degree thresholds need eight integer bits plus the fraction bits
  if (TEMP_W < fan_hyst_pkg::TEMP_W) begin : g_bad_width
    $error("TEMP_W too small for 8-bit thresholds with fraction bits");
  end

  typedef struct packed {
    logic running;
    logic crit;
  } ch_state_s;

  ch_state_s         state_reg;
  ch_state_s         state_next;
  logic signed [CW-1:0] temp_s;
  logic signed [CW-1:0] start_s;
  logic signed [CW-1:0] limit_s;
  logic signed [CW-1:0] hyst_s;

  // Thresholds are whole degrees, temperature carries two fraction bits
  assign temp_s  = {{2{temp_i[TEMP_W-1]}}, temp_i};
  assign start_s = {{(CW-10){start_temp_i[7]}}, start_temp_i, 2'b00};
  assign limit_s = {{(CW-10){crit_limit_i[7]}}, crit_limit_i, 2'b00};
  assign hyst_s  = {{(CW-6){1'b0}}, hyst_i, 2'b00}; // RULE15

  always_comb begin
    state_next = state_reg;
    if (temp_s > start_s) begin
      state_next.running = 1'b1;
    end else if (temp_s <= start_s - hyst_s) begin // RULE5
      state_next.running = 1'b0;
    end
    if (temp_s > limit_s) begin
      state_next.crit = 1'b1;
    end else if (temp_s < limit_s - hyst_s) begin // RULE6
      state_next.crit = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign running_o = state_reg.running;
  assign crit_o    = state_reg.crit;

endmodule

// file: sim/fan_hyst_host.sv
// Host model that reaches the register port the way management software does
module fan_hyst_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic [7:0]      addr_o,
  output logic            wr_o,
  output logic [7:0]      wdata_o,
  output logic            rd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
    rd_o    = 1'b0;
  end

  // One-cycle write strobe; data is scrambled afterwards so nothing leans on a stale byte
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
    wdata_o = ~d;
  endtask

  // Read data is taken one cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_i);
    rd_o   = 1'b0;
    d      = rdata_i;
  endtask
endmodule

// file: sim/fan_hysteresis_offset_regs_properties.sv
// Checker for the fan hysteresis register bank and its loop floor
module fan_hyst_checker #(
  parameter int TEMP_W = fan_hyst_pkg::TEMP_W
) (
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic [7:0]        reg_addr_i,
  input wire logic              reg_wr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              global_lock_i,
  input wire logic [TEMP_W-1:0] cpu_temp_i,
  input wire logic [7:0]        cpu_start_temp_i,
  input wire logic [7:0]        cpu_crit_limit_i,
  input wire logic [7:0]        min_fan_duty_i,
  input wire logic [3:0]        fan_running_o,
  input wire logic [3:0]        fan_crit_o,
  input wire logic [7:0]        fan_duty_floor_o,
  input wire logic              logic_tree_test_on_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_floor_crit;
    fan_crit_o != 4'h0 |=> fan_duty_floor_o == 8'hff;
  endproperty
  a_floor_crit: assert property (p_floor_crit) else $error("floor not full on crit");
  property p_floor_run;
    fan_crit_o == 4'h0 && fan_running_o != 4'h0 |=> fan_duty_floor_o == $past(min_fan_duty_i);
  endproperty
  a_floor_run: assert property (p_floor_run) else $error("floor not min duty");
  property p_floor_off;
    fan_crit_o == 4'h0 && fan_running_o == 4'h0 |=> fan_duty_floor_o == 8'h00;
  endproperty
  a_floor_off: assert property (p_floor_off) else $error("floor not zero");
  property p_test_wr;
    reg_wr_i && !global_lock_i && reg_addr_i == 8'h6f
      |=> logic_tree_test_on_o == $past(reg_wdata_i[0]);
  endproperty
  a_test_wr: assert property (p_test_wr) else $error("test bit not written");
  property p_lock;
    reg_wr_i && global_lock_i && !$past(reg_wr_i) |=> $stable(logic_tree_test_on_o);
  endproperty
  a_lock: assert property (p_lock) else $error("write taken while locked");
  property p_reset;
    $rose(rst_b_i) |-> reg_rdata_o == 8'h00 && !logic_tree_test_on_o && fan_crit_o == 4'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  property p_crit_set;
    $signed(cpu_temp_i) > 4 * $signed(cpu_crit_limit_i) |=> fan_crit_o[2];
  endproperty
  a_crit_set: assert property (p_crit_set) else $error("crit not set above limit");
  property p_run_set;
    $signed(cpu_temp_i) > 4 * $signed(cpu_start_temp_i) |=> fan_running_o[2];
  endproperty
  a_run_set: assert property (p_run_set) else $error("fan not running above start");
  property p_run_clr;
    $signed(cpu_temp_i) <= 4 * ($signed(cpu_start_temp_i) - 15) |=> !fan_running_o[2];
  endproperty
  a_run_clr: assert property (p_run_clr) else $error("fan still running far below start");
endmodule

bind fan_hysteresis_offset_regs fan_hyst_checker #(
  .TEMP_W               (TEMP_W)
) chk (
  .clk_i                (clk_i),
  .rst_b_i              (rst_b_i),
  .reg_addr_i           (reg_addr_i),
  .reg_wr_i             (reg_wr_i),
  .reg_wdata_i          (reg_wdata_i),
  .reg_rdata_o          (reg_rdata_o),
  .global_lock_i        (global_lock_i),
  .cpu_temp_i           (cpu_temp_i),
  .cpu_start_temp_i     (cpu_start_temp_i),
  .cpu_crit_limit_i     (cpu_crit_limit_i),
  .min_fan_duty_i       (min_fan_duty_i),
  .fan_running_o        (fan_running_o),
  .fan_crit_o           (fan_crit_o),
  .fan_duty_floor_o     (fan_duty_floor_o),
  .logic_tree_test_on_o (logic_tree_test_on_o)
);

// file: sim/tb_fan_hysteresis_offset_regs.sv
// Self-checking bench for the fan hysteresis and offset register bank
module tb_fan_hysteresis_offset_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } row_s;
  logic       clk, rst_b, wr, rd, lock, range, test_on;
  logic [7:0] addr, wdata, rdata, min_duty, floor, d;
  logic [9:0] temp [4];
  logic [7:0] start [4];
  logic [7:0] crit [4];
  logic [9:0] adj_on, adj_ra;
  logic [3:0] running, crit_o;
  int         mismatches, compares;
  int         hyst [4] = '{5, 7, 6, 9};
  row_s rows [6] = '{
    '{8'h6d, 8'h75, 8'h75},
    '{8'h6e, 8'h96, 8'h96},
    '{8'h6f, 8'h01, 8'h01},
    '{8'h70, 8'h04, 8'h04},
    '{8'h71, 8'hfe, 8'hfe},
    '{8'h72, 8'h5a, 8'h00}};
  row_s rst_rows [5] = '{'{8'h6d, 8'h00, 8'h44}, '{8'h6e, 8'h00, 8'h44},
    '{8'h6f, 8'h00, 8'h00}, '{8'h70, 8'h00, 8'h00}, '{8'h71, 8'h00, 8'h00}};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  fan_hyst_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
                      .wdata_o(wdata), .rd_o(rd));
  fan_hysteresis_offset_regs #(.TEMP_W(10)) dut (
    .clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .global_lock_i(lock), .offset_range_i(range),
    .onchip_temp_i(temp[0]), .remote_a_temp_i(temp[1]), .cpu_temp_i(temp[2]),
    .remote_b_temp_i(temp[3]), .onchip_start_temp_i(start[0]),
    .remote_a_start_temp_i(start[1]), .cpu_start_temp_i(start[2]),
    .remote_b_start_temp_i(start[3]), .onchip_crit_limit_i(crit[0]),
    .remote_a_crit_limit_i(crit[1]), .cpu_crit_limit_i(crit[2]),
    .remote_b_crit_limit_i(crit[3]), .min_fan_duty_i(min_duty),
    .onchip_temp_adj_o(adj_on), .remote_a_temp_adj_o(adj_ra), .fan_running_o(running),
    .fan_crit_o(crit_o), .fan_duty_floor_o(floor), .logic_tree_test_on_o(test_on));

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  // Walk one channel over its start threshold and back down through the band
  task automatic loop_ch(input int ch, input int h);
    start[ch] = 8'd40;
    temp[ch]  = 10'(41 * 4);
    settle();
    chk(running[ch], 1'b1);
    chk(floor, min_duty);
    temp[ch] = 10'((40 - h) * 4 + 1);
    settle();
    chk(running[ch], 1'b1);
    temp[ch] = 10'((40 - h) * 4);
    settle();
    chk(running[ch], 1'b0);
    chk(floor, 8'h00);
  endtask

  task automatic finish_test();
    $display("Checks made: %0d, mismatches: %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0; lock = 1'b0; range = 1'b1; min_duty = 8'h40;
    for (int i = 0; i < 4; i++) begin
      temp[i] = 10'd0; start[i] = 8'd100; crit[i] = 8'h7f;
    end
    repeat (10) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    foreach (rst_rows[i]) begin
      host.rd_reg(rst_rows[i].a, d);
      chk(d, rst_rows[i].e);
    end
    $display("reset values test done");
    foreach (rows[i]) begin
      host.wr_reg(rows[i].a, rows[i].d);
      host.rd_reg(rows[i].a, d);
      chk(d, rows[i].e);
    end
    chk(test_on, 1'b1);
    $display("register table test done");
    lock = 1'b1;
    host.wr_reg(8'h6d, 8'h00);
    host.wr_reg(8'h6f, 8'h00);
    host.rd_reg(8'h6d, d);
    chk(d, 8'h75);
    chk(test_on, 1'b1);
    lock = 1'b0;
    host.wr_reg(8'h6f, 8'h00);
    chk(test_on, 1'b0);
    $display("lock test done");
    temp[0] = 10'd100;
    temp[1] = 10'd100;
    settle();
    chk(adj_ra, 10'd116);
    chk(adj_on, 10'd92);
    range = 1'b0;
    settle();
    chk(adj_ra, 10'd108);
    chk(adj_on, 10'd96);
    range = 1'b1;
    host.wr_reg(8'h70, 8'h00);
    host.wr_reg(8'h71, 8'h00);
    $display("offset test done");
    for (int ch = 0; ch < 4; ch++) begin
      loop_ch(ch, hyst[ch]);
    end
    $display("hysteresis test done");
    crit[2] = 8'd50;
    temp[2] = 10'(51 * 4);
    settle();
    chk(crit_o[2], 1'b1);
    chk(floor, 8'hff);
    temp[2] = 10'(44 * 4);
    settle();
    chk(crit_o[2], 1'b1);
    temp[2] = 10'(44 * 4 - 1);
    settle();
    chk(crit_o[2], 1'b0);
    chk(floor, min_duty);
    $display("critical limit test done");
    finish_test();
  end
endmodule
